//--- ptd_regs.sv
`timescale 1ns/1ps
`include "ptd_map.svh"
// What this block does
// - Bit 13 of the 10BASE-Te register lowers the receive threshold when set.
// - Bits 12:9 pick the squelch level from 200mV in 50mV steps, reset 0000.
// - Bit 7 set stops normal link pulses, clear (reset) lets them go.
// - Bit 4 mirrors the status polarity bit and both clear on a read of the 10BASE-Te register or on a software reset.
// - Bit 0 set disables jabber, which matters only in 10BASE-Te.
// - Bits 15:8 of self-test register one show the errored byte count.
// - Writing 1 to bit 15 there locks the count for reading and clears the running counter.
// - In saturate mode the count stops at its maximum.
// - Bits 7:0 set the inter-packet gap, reset 0x7D.
// - Bits 10:0 of self-test register two set packet length, reset 0x5EE.
// - Cable start bit 15 is set by the host and cleared when done rises.
// - Done bit 1 reads 1 after the measurement completes.
// - Fail bit 0 reads 1 when the measurement failed.
// - Software reset bit 15 resets the whole PHY like the pin and clears itself.
// - Digital restart bit 14 resets digital logic and the errored byte count, clears cable start, keeps other registers and clears itself.
module ptd_regs (
	input  wire logic   clock_in,       // 40 MHz clock
	input  wire logic   rst_in,         // Hardware reset
	input  ptd_pkg::ptd_mgmt_req_t req_in, // Register access
	input  wire logic   pol_event_in,   // Inverted polarity seen
	input  wire logic   err_byte_in,    // Checker errored byte
	input  wire logic   cnt_wrap_in,    // Counter mode bit
	input  wire logic   cd_done_in,     // Cable engine done pulse
	input  wire logic   cd_fail_in,     // Cable engine fail pulse
	output logic [15:0] rdata_out,      // Read data
	output ptd_pkg::ptd_ctrl_t ctrl_out, // Controls to PHY
	output logic        sts_pol_out,    // Status register copy
	output logic        sw_reset_out,   // Whole PHY reset pulse
	output logic        dig_restart_out // Digital restart pulse
);
	import ptd_pkg::*;

	// ==========================================
	// State
	typedef struct packed {
		ptd_ctrl_t   ctrl;
		logic        pol;
		logic        cd_done;
		logic        cd_fail;
		logic        sw_rst;
		logic        dig_rst;
		logic [15:0] rdata;
	} ptd_state_t;

	ptd_state_t state;
	ptd_state_t next_state;
	ptd_cnt_t   cnt;
	logic       lock_pulse;
	logic       dig_clear;

	function automatic logic hit(input logic [4:0] a, input logic [4:0] want);
		hit = (a == want);
	endfunction

	assign lock_pulse = req_in.wr && hit(req_in.addr, `PTD_ADDR_SELFTEST1)
		&& req_in.wdata[`PTD_ST1_LOCK_BIT];
	// Soft reset acts as hardware reset on following cycle
	assign dig_clear = state.sw_rst || state.dig_rst;

	// ==========================================
	// Error counter
	ptd_err_counter #(
		.WIDTH (8)
	) u_cnt (
		.clock_in (clock_in),
		.rst_in   (rst_in),
		.clr_in   (dig_clear),
		.err_in   (err_byte_in),
		.wrap_in  (cnt_wrap_in),
		.lock_in  (lock_pulse),
		.cnt_out  (cnt)
	);

	// ==========================================
	// Next state
	always_comb begin
		next_state = state;
		next_state.sw_rst  = 1'b0;
		next_state.dig_rst = 1'b0;
		// Read mux, reserved bits zero
		next_state.rdata = 16'h0000;
		if (req_in.rd) begin
			unique case (req_in.addr)
				`PTD_ADDR_TENBASE: begin
					next_state.rdata[`PTD_TB_LOWTHR_BIT] = state.ctrl.low_thresh;
					next_state.rdata[`PTD_TB_SQ_HI:`PTD_TB_SQ_LO] = state.ctrl.squelch;
					next_state.rdata[`PTD_TB_NLP_BIT] = state.ctrl.nlp_disable;
					next_state.rdata[`PTD_TB_POL_BIT] = state.pol;
					next_state.rdata[`PTD_TB_JAB_BIT] = state.ctrl.jabber_disable;
				end
				`PTD_ADDR_SELFTEST1: begin
					next_state.rdata[`PTD_ST1_CNT_HI:`PTD_ST1_CNT_LO] = cnt.locked;
					next_state.rdata[`PTD_ST1_IPG_HI:`PTD_ST1_IPG_LO] = state.ctrl.ipg_len;
				end
				`PTD_ADDR_SELFTEST2:
					next_state.rdata[`PTD_ST2_LEN_HI:`PTD_ST2_LEN_LO] = state.ctrl.pkt_len;
				`PTD_ADDR_CABLEDIAG: begin
					next_state.rdata[`PTD_CD_START_BIT] = state.ctrl.cable_start;
					next_state.rdata[`PTD_CD_DONE_BIT] = state.cd_done;
					next_state.rdata[`PTD_CD_FAIL_BIT] = state.cd_fail;
				end
				default: next_state.rdata = 16'h0000;
			endcase
		end
		// Polarity read clear, new event wins
		if (req_in.rd && hit(req_in.addr, `PTD_ADDR_TENBASE))
			next_state.pol = 1'b0;
		if (pol_event_in)
			next_state.pol = 1'b1;
		// Writes
		if (req_in.wr) begin
			unique case (req_in.addr)
				`PTD_ADDR_TENBASE: begin
					next_state.ctrl.low_thresh = req_in.wdata[`PTD_TB_LOWTHR_BIT];
					next_state.ctrl.squelch = req_in.wdata[`PTD_TB_SQ_HI:`PTD_TB_SQ_LO];
					next_state.ctrl.nlp_disable = req_in.wdata[`PTD_TB_NLP_BIT];
					next_state.ctrl.jabber_disable = req_in.wdata[`PTD_TB_JAB_BIT];
				end
				`PTD_ADDR_SELFTEST1:
					next_state.ctrl.ipg_len = req_in.wdata[`PTD_ST1_IPG_HI:`PTD_ST1_IPG_LO];
				`PTD_ADDR_SELFTEST2:
					next_state.ctrl.pkt_len = req_in.wdata[`PTD_ST2_LEN_HI:`PTD_ST2_LEN_LO];
				`PTD_ADDR_CABLEDIAG:
					if (req_in.wdata[`PTD_CD_START_BIT]) begin
						next_state.ctrl.cable_start = 1'b1;
						next_state.cd_done = 1'b0;
						next_state.cd_fail = 1'b0;
					end
				`PTD_ADDR_RESETCTRL: begin
					next_state.sw_rst  = req_in.wdata[`PTD_RC_SWRST_BIT];
					next_state.dig_rst = req_in.wdata[`PTD_RC_DIGRST_BIT];
				end
				default: ;
			endcase
		end
		// Cable engine completion
		if (cd_done_in) begin
			next_state.cd_done = 1'b1;
			next_state.cd_fail = cd_fail_in;
			next_state.ctrl.cable_start = 1'b0;
		end
		// Digital restart keeps registers, stops measurement
		if (state.dig_rst)
			next_state.ctrl.cable_start = 1'b0;
		// Software reset returns everything to defaults
		if (state.sw_rst) begin
			next_state = '0;
			next_state.ctrl.ipg_len = `PTD_IPG_RESET;
			next_state.ctrl.pkt_len = `PTD_LEN_RESET;
			next_state.ctrl.squelch = `PTD_SQ_RESET;
		end
	end

	// ==========================================
	// State register
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			state <= '0;
			state.ctrl.ipg_len <= `PTD_IPG_RESET;
			state.ctrl.pkt_len <= `PTD_LEN_RESET;
			state.ctrl.squelch <= `PTD_SQ_RESET;
		end else begin
			state <= next_state;
		end
	end

	// Outputs
	assign rdata_out       = state.rdata;
	assign ctrl_out        = state.ctrl;
	assign sts_pol_out     = state.pol;
	assign sw_reset_out    = state.sw_rst;
	assign dig_restart_out = state.dig_rst;
endmodule

//--- ptd_map.svh
`ifndef PTD_MAP_SVH
`define PTD_MAP_SVH
// ==========================================
// Register addresses
`define PTD_ADDR_TENBASE     5'h1A
`define PTD_ADDR_SELFTEST1   5'h1B
`define PTD_ADDR_SELFTEST2   5'h1C
`define PTD_ADDR_CABLEDIAG   5'h1E
`define PTD_ADDR_RESETCTRL   5'h1F
// ==========================================
// Field positions
`define PTD_TB_LOWTHR_BIT    13
`define PTD_TB_SQ_HI         12
`define PTD_TB_SQ_LO         9
`define PTD_TB_NLP_BIT       7
`define PTD_TB_POL_BIT       4
`define PTD_TB_JAB_BIT       0
`define PTD_ST1_LOCK_BIT     15
`define PTD_ST1_CNT_HI       15
`define PTD_ST1_CNT_LO       8
`define PTD_ST1_IPG_HI       7
`define PTD_ST1_IPG_LO       0
`define PTD_ST2_LEN_HI       10
`define PTD_ST2_LEN_LO       0
`define PTD_CD_START_BIT     15
`define PTD_CD_DONE_BIT      1
`define PTD_CD_FAIL_BIT      0
`define PTD_RC_SWRST_BIT     15
`define PTD_RC_DIGRST_BIT    14
// ==========================================
// Reset values
`define PTD_SQ_RESET         4'h0
`define PTD_IPG_RESET        8'h7D
`define PTD_LEN_RESET        11'h5EE
`define PTD_CNT_MAX          8'hFF
`define PTD_CNT_ZERO         8'h00
`define PTD_ONE_BYTE         8'h01
`endif

//--- ptd_pkg.sv
package ptd_pkg;
	// ==========================================
	// Management access carrier
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [4:0]  addr;
		logic [15:0] wdata;
	} ptd_mgmt_req_t;

	// Controls handed to analog and digital PHY
	typedef struct packed {
		logic        low_thresh;
		logic [3:0]  squelch;
		logic        nlp_disable;
		logic        jabber_disable;
		logic [7:0]  ipg_len;
		logic [10:0] pkt_len;
		logic        cable_start;
	} ptd_ctrl_t;

	// Error counter state
	typedef struct packed {
		logic [7:0] running;
		logic [7:0] locked;
	} ptd_cnt_t;
endpackage

//--- ptd_err_counter.sv
`timescale 1ns/1ps
`include "ptd_map.svh"
// ==========================================
// Self-test errored byte counter
module ptd_err_counter #(
	parameter int WIDTH = 8
) (
	input  wire logic   clock_in,   // Clock
	input  wire logic   rst_in,     // Async reset
	input  wire logic   clr_in,     // Sync clear
	input  wire logic   err_in,     // Errored byte pulse
	input  wire logic   wrap_in,    // 1 wraps, 0 saturates
	input  wire logic   lock_in,    // Lock and clear pulse
	output ptd_pkg::ptd_cnt_t cnt_out // Counter state
);
	import ptd_pkg::*;
	ptd_cnt_t state;
	ptd_cnt_t next_state;

	// Count, saturate, lock
	always_comb begin
		next_state = state;
		if (err_in && (wrap_in || state.running != `PTD_CNT_MAX))
			next_state.running = state.running + `PTD_ONE_BYTE;
		if (lock_in) begin
			next_state.locked  = state.running;
			next_state.running = err_in ? `PTD_ONE_BYTE : `PTD_CNT_ZERO;
		end
		if (clr_in) begin
			next_state = '0;
		end
	end

	// State register
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in)
			state <= '0;
		else
			state <= next_state;
	end

	assign cnt_out = state;
endmodule

//--- ptd_regs_props.sv
`timescale 1ns/1ps
// ==========================================
// Port checker for the register bank
module ptd_regs_props (
	input logic                   clock_in,       // Clock
	input logic                   rst_in,         // Reset
	input ptd_pkg::ptd_mgmt_req_t req_in,         // Access
	input logic                   pol_event_in,   // Polarity
	input logic                   cd_done_in,     // Done
	input logic [15:0]            rdata_out,      // Read data
	input ptd_pkg::ptd_ctrl_t     ctrl_out,       // Controls
	input logic                   sts_pol_out,    // Status copy
	input logic                   sw_reset_out,   // Soft reset
	input logic                   dig_restart_out // Restart
);
	import ptd_pkg::*;
	default clocking @(posedge clock_in); endclocking
	default disable iff (rst_in);
	// Access steps
	sequence wr_at(a);
		req_in.wr && req_in.addr == a;
	endsequence
	sequence rd_at(a);
		req_in.rd && req_in.addr == a;
	endsequence
	swrst_cause_a: assert property (wr_at(5'h1F) ##0 req_in.wdata[15] |=> sw_reset_out)
		else $error("soft reset pulse missing");
	swrst_pulse_a: assert property (sw_reset_out |=> !sw_reset_out && ctrl_out.ipg_len == 8'h7D
		&& ctrl_out.pkt_len == 11'h5EE && ctrl_out.squelch == 4'h0) else $error("soft reset bad");
	digrst_pulse_a: assert property (wr_at(5'h1F) ##0 req_in.wdata[14] |=> dig_restart_out ##1
		!dig_restart_out) else $error("restart pulse bad");
	squelch_wr_a: assert property (wr_at(5'h1A) |=> ctrl_out.squelch == $past(req_in.wdata[12:9]))
		else $error("squelch not written");
	cd_start_a: assert property (wr_at(5'h1E) ##0 req_in.wdata[15] |=> ctrl_out.cable_start)
		else $error("start not set");
	cd_clear_a: assert property (cd_done_in && !req_in.wr |=> !ctrl_out.cable_start)
		else $error("start not cleared");
	pol_set_a: assert property (pol_event_in |=> sts_pol_out) else $error("polarity not set");
	pol_clear_a: assert property (rd_at(5'h1A) ##0 !pol_event_in |=> !sts_pol_out)
		else $error("polarity not cleared");
	pol_read_a: assert property (rd_at(5'h1A) |=> rdata_out[4] == $past(sts_pol_out)
		&& rdata_out[15:14] == 2'h0) else $error("polarity read bad");
	unmapped_rd_a: assert property (req_in.rd && (req_in.addr < 5'h1A || req_in.addr == 5'h1D)
		|=> rdata_out == 16'h0000) else $error("unmapped read not zero");
endmodule
bind ptd_regs ptd_regs_props props (.*);

//--- ptd_host.sv
`timescale 1ns/1ps
// ==========================================
// Management host model
module ptd_host (
	input  wire logic              clock_in, // Clock
	output ptd_pkg::ptd_mgmt_req_t req_out   // Requests
);
	import ptd_pkg::*;
	int seed = 32'h1CD3650B;
	initial req_out = '0;
	// Random value source
	function automatic logic [15:0] rnd();
		return 16'($random(seed));
	endfunction
	// One access after one or two idle cycles
	task automatic acc(input logic r, input logic [4:0] a, input logic [15:0] d);
		repeat (1 + ($unsigned($random(seed)) % 2)) @(negedge clock_in);
		req_out <= '{r, !r, a, d};
		@(negedge clock_in);
		req_out <= '0;
	endtask
endmodule

//--- tb_ptd_regs.sv
`timescale 1ns/1ps
module tb_ptd_regs;
	import ptd_pkg::*;
	logic           clock_in = 0;
	logic           rst_in = 1;
	logic           pol = 0;
	logic           err = 0;
	logic           wrap = 0;
	logic           done = 0;
	logic           fail = 0;
	logic           rd_d = 0;
	logic [15:0]    rdata;
	logic [15:0]    d;
	logic [15:0]    cfg;
	logic [15:0]    exp_q[$];
	ptd_mgmt_req_t  req;
	ptd_ctrl_t      ctrl;
	int             n_checks = 0;
	int             num_errors = 0;
	initial forever #12.5 clock_in = ~clock_in;
	ptd_host h (.clock_in(clock_in), .req_out(req));
	ptd_regs dut (.clock_in(clock_in), .rst_in(rst_in), .req_in(req), .pol_event_in(pol),
		.err_byte_in(err), .cnt_wrap_in(wrap), .cd_done_in(done), .cd_fail_in(fail),
		.rdata_out(rdata), .ctrl_out(ctrl), .sts_pol_out(), .sw_reset_out(), .dig_restart_out());
	// Compare and count
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		n_checks++;
		if (s !== e) begin
			num_errors++;
			$display("mismatch %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic rd(input logic [4:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		h.acc(1, a, 16'h0000);
	endtask
	task automatic errs(input int n);
		repeat (n) @(negedge clock_in) err <= 1;
		@(negedge clock_in) err <= 0;
	endtask
	task automatic cd(input logic f);
		@(negedge clock_in) {done, fail} <= {1'b1, f};
		@(negedge clock_in) {done, fail} <= 2'b00;
	endtask
	task tally_and_finish;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Read answers checked against oldest note
	always @(posedge clock_in) rd_d <= req.rd;
	always @(negedge clock_in) if (rd_d) chk("rdata", rdata, exp_q.pop_front());
	initial begin
		#100000;
		num_errors++;
		tally_and_finish;
	end
	// Main sequence
	initial begin
		repeat (16) @(negedge clock_in);
		rst_in = 0;
		rd(5'h1B, 16'h007D);
		rd(5'h1C, 16'h05EE);
		rd(5'h1D, 16'h0000);
		rd(5'h1E, 16'h0000);
		for (int i = 0; i < 4; i++) begin
			d = h.rnd();
			cfg = d & 16'h3E81;
			h.acc(0, 5'h1A, d);
			rd(5'h1A, cfg);
			chk("squelch", {12'h000, ctrl.squelch}, {12'h000, cfg[12:9]});
			chk("tb_ctrl", {9'h000, ctrl.low_thresh, ctrl.squelch, ctrl.nlp_disable, ctrl.jabber_disable}, {9'h000, cfg[13:9], cfg[7], cfg[0]});
		end
		@(negedge clock_in) pol <= 1;
		@(negedge clock_in) pol <= 0;
		rd(5'h1A, cfg | 16'h0010);
		rd(5'h1A, cfg);
		errs(5);
		h.acc(0, 5'h1B, 16'h807D);
		rd(5'h1B, 16'h057D);
		errs(300);
		h.acc(0, 5'h1B, 16'h807D);
		rd(5'h1B, 16'hFF7D);
		wrap <= 1;
		errs(260);
		h.acc(0, 5'h1B, 16'h807D);
		rd(5'h1B, 16'h047D);
		d = h.rnd();
		h.acc(0, 5'h1C, d);
		rd(5'h1C, d & 16'h07FF);
		chk("pkt_len", {5'h00, ctrl.pkt_len}, d & 16'h07FF);
		h.acc(0, 5'h1E, 16'h8000);
		rd(5'h1E, 16'h8000);
		chk("cable_start", {15'h0000, ctrl.cable_start}, 16'h0001);
		cd(1);
		rd(5'h1E, 16'h0003);
		h.acc(0, 5'h1E, 16'h8000);
		cd(0);
		rd(5'h1E, 16'h0002);
		h.acc(0, 5'h1F, 16'h4000);
		rd(5'h1A, cfg);
		rd(5'h1F, 16'h0000);
		h.acc(0, 5'h1F, 16'h8000);
		repeat (2) @(negedge clock_in);
		rd(5'h1A, 16'h0000);
		rd(5'h1B, 16'h007D);
		repeat (2) @(negedge clock_in);
		tally_and_finish;
	end
endmodule
